// ===== hw/qam_constellation_mapper.sv
// Per-tone QAM constellation mapper with gain normalisation
`default_nettype none
// Contract
// - A tone carrying a single bit is always accepted and mapped; the code maps it to the origin while the selected ceiling is out of range.
// - Each direction's bit ceiling lies in 8..15 and no tone may exceed it.
// - Each tone yields a point whose X and Y are odd integers on a grid; the code maps tones flagged on out_err to the origin instead.
// - The tone bits form an unsigned label with the top bit most significant.
// - Even sizes build X from odd bits and Y from even bits, each ending in 1.
// - For even sizes the top bit is the sign of X and the next that of Y.
// - Every size is scaled to the same RMS energy.
// - Each even size expands the smaller one by the 4n+1,4n+3 / 4n,4n+2 block.
// - Odd sizes above 3 prefix two table bits to the interleaved low bits.
// - The two table bits come from the five top label bits via a 32-entry table.
// - Larger odd sizes expand the 5-bit one by the same 2x2 block.
module qam_constellation_mapper (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                srst,
	// Tone input from the bit extractor
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  wire logic [14:0]         in_bits,
	input  wire logic [3:0]          in_nbits,
	input  wire logic                in_dir,
	// Negotiated ceilings, 0 downstream 1 upstream
	input  wire logic [3:0]          bmax_dn,
	input  wire logic [3:0]          bmax_up,
	// Point output to the gain stage
	output logic                     out_valid,
	input  wire logic                out_ready,
	output qam_map_pkg::coord_t      out_x,
	output qam_map_pkg::coord_t      out_y,
	output qam_map_pkg::coord_t      out_pt_x,
	output qam_map_pkg::coord_t      out_pt_y,
	output logic [3:0]               out_nbits,
	output logic                     out_err,
	// Ceiling configuration outside its range
	output logic                     cfg_err
);
	qam_lut_if lut_bus ();

	logic                adv;
	logic                v1_r, v2_r, v3_r, v1_nxt, v2_nxt, v3_nxt;
	logic [15:0]         bits_r, bits_nxt;
	logic [3:0]          nb1_r, nb1_nxt, nb2_r, nb2_nxt, nb3_r, nb3_nxt;
	logic                e1_r, e1_nxt, e2_r, e2_nxt, e3_r, e3_nxt;
	logic                cfg_r, cfg_nxt;
	logic [3:0]          bmax_sel;
	logic                bmax_bad;
	logic [3:0]          m;
	logic [7:0]          xl, yl;
	logic [15:0]         xv, yv;
	logic [3:0]          sp;
	qam_map_pkg::coord_t rx, ry, rx_r, ry_r, rx_nxt, ry_nxt;
	qam_map_pkg::coord_t ox_r, oy_r, ox_nxt, oy_nxt, px_r, py_r;
	logic signed [32:0]  prod_x, prod_y;
	logic [15:0]         scl;

	qam_lut u_lut (
		.core_clk (core_clk),
		.srst     (srst),
		.lut      (lut_bus.rom)
	);

	// Sign-extend a raw two's complement field whose sign sits at bit sp
	function automatic qam_map_pkg::coord_t sext(input logic [15:0] v,
		input logic [3:0] s);
		logic [15:0] r;
		r = v;
		for (int i = 0; i < 16; i++) begin
			if (i > int'(s))
				r[i] = v[s];
		end
		return qam_map_pkg::coord_t'(r);
	endfunction

	// Whole pipeline moves together; a stalled sink holds every stage
	assign adv      = ~v3_r | out_ready;
	assign in_ready = adv;

	// Ceiling check per direction
	assign bmax_sel = in_dir ? bmax_up : bmax_dn;
	assign bmax_bad = (bmax_sel < qam_map_pkg::BMAX_MIN) ||
		(bmax_sel > qam_map_pkg::BMAX_MAX);

	// Table address: five leading label bits, or the whole small label
	assign lut_bus.en   = adv;
	assign lut_bus.one  = (in_nbits == qam_map_pkg::NB_ONE);
	assign lut_bus.addr = (in_nbits >= qam_map_pkg::NB_FIVE) ?
		5'(in_bits >> (in_nbits - qam_map_pkg::NB_FIVE)) :
		in_bits[4:0];

	// Stage one captures the tone label
	always_comb begin
		v1_nxt   = v1_r;
		bits_nxt = bits_r;
		nb1_nxt  = nb1_r;
		e1_nxt   = e1_r;
		cfg_nxt  = bmax_bad;
		if (adv) begin
			v1_nxt   = in_valid;
			bits_nxt = {1'b0, in_bits};
			nb1_nxt  = in_nbits;
			// Zero-bit tones and tones above the ceiling map to the origin
			e1_nxt   = (in_nbits == 4'h0) || bmax_bad ||
				(in_nbits > bmax_sel);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			v1_r   <= 1'b0;
			bits_r <= 16'h0000;
			nb1_r  <= 4'h0;
			e1_r   <= 1'b0;
			cfg_r  <= 1'b0;
		end else begin
			v1_r   <= v1_nxt;
			bits_r <= bits_nxt;
			nb1_r  <= nb1_nxt;
			e1_r   <= e1_nxt;
			cfg_r  <= cfg_nxt;
		end
	end

	// Interleave the low label bits: odd ones to X, even ones to Y
	always_comb begin
		// Odd sizes keep (b-3)/2 low pairs below the two table bits
		m  = nb1_r[0] ? ((nb1_r - qam_map_pkg::NB_THREE) >> 1) : (nb1_r >> 1);
		xl = 8'h00;
		yl = 8'h00;
		for (int k = 0; k < qam_map_pkg::LOW_W; k++) begin
			if (k < int'(m)) begin
				xl[k] = bits_r[2 * k + 1];
				yl[k] = bits_r[2 * k];
			end
		end
		// Trailing 1 keeps points odd; each level adds one 2x2 block bit
		xv = {7'h00, xl, 1'b1};
		yv = {7'h00, yl, 1'b1};
		sp = m;
		if (nb1_r[0]) begin
			xv = xv | ({14'h0000, lut_bus.top_x} << (m + 4'h1));
			yv = yv | ({14'h0000, lut_bus.top_y} << (m + 4'h1));
			sp = m + 4'h2;
		end
		rx = sext(xv, sp);
		ry = sext(yv, sp);
		if (e1_r) begin
			rx = '0;
			ry = '0;
		end else if (nb1_r == qam_map_pkg::NB_ONE ||
			nb1_r == qam_map_pkg::NB_THREE) begin
			rx = qam_map_pkg::coord_t'(lut_bus.sm_x);
			ry = qam_map_pkg::coord_t'(lut_bus.sm_y);
		end
	end

	// Stage two holds the integer point; stage three the scaled one
	always_comb begin
		v2_nxt  = v2_r;
		nb2_nxt = nb2_r;
		e2_nxt  = e2_r;
		rx_nxt  = rx_r;
		ry_nxt  = ry_r;
		v3_nxt  = v3_r;
		nb3_nxt = nb3_r;
		e3_nxt  = e3_r;
		ox_nxt  = ox_r;
		oy_nxt  = oy_r;
		scl     = qam_map_pkg::scale_of(nb2_r);
		prod_x  = 33'(rx_r) * $signed({17'h00000, scl});
		prod_y  = 33'(ry_r) * $signed({17'h00000, scl});
		if (adv) begin
			v2_nxt  = v1_r;
			nb2_nxt = nb1_r;
			e2_nxt  = e1_r;
			rx_nxt  = rx;
			ry_nxt  = ry;
			v3_nxt  = v2_r;
			nb3_nxt = nb2_r;
			e3_nxt  = e2_r;
			// Q2.13 output; the shift keeps headroom for the largest grid
			ox_nxt  = prod_x[qam_map_pkg::SCALE_SHIFT +: 16];
			oy_nxt  = prod_y[qam_map_pkg::SCALE_SHIFT +: 16];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			v2_r  <= 1'b0;
			nb2_r <= 4'h0;
			e2_r  <= 1'b0;
			rx_r  <= '0;
			ry_r  <= '0;
			v3_r  <= 1'b0;
			nb3_r <= 4'h0;
			e3_r  <= 1'b0;
			ox_r  <= '0;
			oy_r  <= '0;
			px_r  <= '0;
			py_r  <= '0;
		end else begin
			v2_r  <= v2_nxt;
			nb2_r <= nb2_nxt;
			e2_r  <= e2_nxt;
			rx_r  <= rx_nxt;
			ry_r  <= ry_nxt;
			v3_r  <= v3_nxt;
			nb3_r <= nb3_nxt;
			e3_r  <= e3_nxt;
			ox_r  <= ox_nxt;
			oy_r  <= oy_nxt;
			px_r  <= adv ? rx_r : px_r;
			py_r  <= adv ? ry_r : py_r;
		end
	end

	assign out_valid = v3_r;
	assign out_x     = ox_r;
	assign out_y     = oy_r;
	assign out_pt_x  = px_r;
	assign out_pt_y  = py_r;
	assign out_nbits = nb3_r;
	assign out_err   = e3_r;
	assign cfg_err   = cfg_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence take_one_s;
		adv && in_valid && in_nbits == qam_map_pkg::NB_ONE && !bmax_bad;
	endsequence
	sequence take_over_s;
		adv && in_valid && !bmax_bad && in_nbits > bmax_sel;
	endsequence
	sequence stage1_even_s;
		v1_r && !e1_r && !nb1_r[0] && adv;
	endsequence

	one_bit_map_a: assert property (take_one_s ##1 1'b1 |->
		(rx == 16'sh0001 || rx == -16'sh0001) && rx == ry)
		else $error("single-bit tone not mapped to a diagonal unit point");
	over_ceiling_a: assert property (take_over_s |->
		##1 e1_r)
		else $error("tone above the ceiling not flagged");
	odd_point_a: assert property (v3_r && !e3_r |->
		out_pt_x[0] && out_pt_y[0])
		else $error("output point is not odd");
	two_bit_x_a: assert property (v1_r && !e1_r && nb1_r == qam_map_pkg::NB_TWO
		&& adv |=> rx_r == ($past(bits_r[1]) ? -16'sh0001 : 16'sh0001))
		else $error("two-bit X does not follow the label");
	even_sign_a: assert property (stage1_even_s |=>
		rx_r[15] == $past(bits_r[nb1_r - 4'h1]) &&
		ry_r[15] == $past(bits_r[nb1_r - 4'h2]))
		else $error("even-size sign bits wrong");
	// Within each 2x2 block v1 picks the right column and v0 the top row
	block_bits_a: assert property (stage1_even_s ##0
		nb1_r >= qam_map_pkg::NB_FOUR |=> rx_r[1] == $past(bits_r[1]) &&
		ry_r[1] == $past(bits_r[0]))
		else $error("block expansion bits wrong");
	label18_a: assert property (v1_r && !e1_r && nb1_r == qam_map_pkg::NB_FIVE
		&& bits_r[4:0] == qam_map_pkg::LABEL_18 && adv |=>
		rx_r == -16'sh0005 && ry_r == 16'sh0001)
		else $error("five-bit label 18 misplaced");
	scale_two_a: assert property (v2_r && adv && nb2_r == qam_map_pkg::NB_TWO &&
		rx_r == 16'sh0001 |=> out_x == 16'sh16A0)
		else $error("two-bit gain wrong");
	stall_hold_a: assert property (v3_r && !out_ready |=> $stable(out_x) &&
		$stable(out_pt_y) && v3_r)
		else $error("output changed while stalled");
endmodule
`default_nettype wire

// ===== hw/qam_map_pkg.sv
// Shared widths, limits and gain table for the constellation mapper
`default_nettype none
package qam_map_pkg;
	localparam int NB_W        = 4;
	localparam int BITS_W      = 15;
	localparam int COORD_W     = 16;
	localparam int SCALE_W     = 16;
	localparam int LOW_W       = 8;
	localparam int TOP_W       = 5;
	localparam int SCALE_SHIFT = 2;
	localparam logic [NB_W-1:0] BMAX_MIN = 4'h8;
	localparam logic [NB_W-1:0] BMAX_MAX = 4'hF;
	localparam logic [NB_W-1:0] NB_ONE   = 4'h1;
	localparam logic [NB_W-1:0] NB_THREE = 4'h3;
	localparam logic [NB_W-1:0] NB_FIVE  = 4'h5;
	localparam logic [NB_W-1:0] NB_TWO   = 4'h2;
	localparam logic [NB_W-1:0] NB_FOUR  = 4'h4;
	localparam logic [TOP_W-1:0] LABEL_18 = 5'h12;

	typedef logic signed [COORD_W-1:0] coord_t;
	typedef logic signed [2:0]         small_t;

	// Gain per bit count: 2^15 / sqrt(mean point energy), equal RMS for all
	function automatic logic [SCALE_W-1:0] scale_of(input logic [NB_W-1:0] nb);
		logic [SCALE_W-1:0] s;
		s = 16'h0000;
		case (nb)
			4'h1: s = 16'h5A82;
			4'h2: s = 16'h5A82;
			4'h3: s = 16'h3441;
			4'h4: s = 16'h287A;
			4'h5: s = 16'h1C9F;
			4'h6: s = 16'h13C0;
			4'h7: s = 16'h0E23;
			4'h8: s = 16'h09D1;
			4'h9: s = 16'h070C;
			4'hA: s = 16'h04E7;
			4'hB: s = 16'h0385;
			4'hC: s = 16'h0273;
			4'hD: s = 16'h01C3;
			4'hE: s = 16'h013A;
			4'hF: s = 16'h00E1;
			default: s = 16'h0000;
		endcase
		return s;
	endfunction
endpackage
`default_nettype wire

// ===== hw/qam_lut_if.sv
// Carrier between the mapper and its lookup tables
`default_nettype none
interface qam_lut_if;
	logic                      en;
	logic [4:0]                addr;
	logic                      one;
	logic [1:0]                top_x;
	logic [1:0]                top_y;
	qam_map_pkg::small_t       sm_x;
	qam_map_pkg::small_t       sm_y;
	modport user (output en, output addr, output one,
		input top_x, input top_y, input sm_x, input sm_y);
	modport rom (input en, input addr, input one,
		output top_x, output top_y, output sm_x, output sm_y);
endinterface
`default_nettype wire

// ===== hw/qam_lut.sv
// Registered lookup of the 5-bit top-bit table and the 1- and 3-bit points
`default_nettype none
module qam_lut (
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   srst,
	// Table port
	qam_lut_if.rom      lut
);
	logic [3:0]          top_nxt, top_r;
	qam_map_pkg::small_t sx_nxt, sy_nxt, sx_r, sy_r;

	// Top two bits of X then Y, indexed by the five leading label bits
	function automatic logic [3:0] top_of(input logic [4:0] a);
		logic [3:0] t;
		t = 4'h0;
		case (a)
			5'h00, 5'h01, 5'h02, 5'h03: t = 4'h0;
			5'h04, 5'h05, 5'h06, 5'h07: t = 4'h3;
			5'h08, 5'h09, 5'h0A, 5'h0B: t = 4'hC;
			5'h0C, 5'h0D, 5'h0E, 5'h0F: t = 4'hF;
			5'h10, 5'h11:               t = 4'h4;
			5'h12, 5'h13:               t = 4'h8;
			5'h14, 5'h16:               t = 4'h1;
			5'h15, 5'h17:               t = 4'h2;
			5'h18, 5'h1A:               t = 4'hD;
			5'h19, 5'h1B:               t = 4'hE;
			5'h1C, 5'h1D:               t = 4'h7;
			default:                    t = 4'hB;
		endcase
		return t;
	endfunction

	// Next table outputs; small points cover the 1- and 3-bit tones
	always_comb begin
		top_nxt = top_of(lut.addr);
		sx_nxt  = 3'sh1;
		sy_nxt  = 3'sh1;
		if (lut.one) begin
			sx_nxt = lut.addr[0] ? -3'sh1 : 3'sh1;
			sy_nxt = lut.addr[0] ? -3'sh1 : 3'sh1;
		end else begin
			case (lut.addr[2:0])
				3'h0: begin sx_nxt = 3'sh1;  sy_nxt = 3'sh1;  end
				3'h1: begin sx_nxt = 3'sh1;  sy_nxt = -3'sh1; end
				3'h2: begin sx_nxt = -3'sh1; sy_nxt = 3'sh1;  end
				3'h3: begin sx_nxt = -3'sh1; sy_nxt = -3'sh1; end
				3'h4: begin sx_nxt = -3'sh3; sy_nxt = 3'sh1;  end
				3'h5: begin sx_nxt = 3'sh1;  sy_nxt = 3'sh3;  end
				3'h6: begin sx_nxt = -3'sh1; sy_nxt = -3'sh3; end
				default: begin sx_nxt = 3'sh3; sy_nxt = -3'sh1; end
			endcase
		end
	end

	// Read data held while the pipeline stalls
	always_ff @(posedge core_clk) begin
		if (srst) begin
			top_r <= 4'h0;
			sx_r  <= 3'sh1;
			sy_r  <= 3'sh1;
		end else if (lut.en) begin
			top_r <= top_nxt;
			sx_r  <= sx_nxt;
			sy_r  <= sy_nxt;
		end
	end

	assign lut.top_x = top_r[3:2];
	assign lut.top_y = top_r[1:0];
	assign lut.sm_x  = sx_r;
	assign lut.sm_y  = sy_r;
endmodule
`default_nettype wire

// ===== bench/gain_sink.sv
// Gain stage model: takes mapped points and stalls at random when asked
`default_nettype none
module gain_sink (
	// Clock
	input  wire logic core_clk,
	// Stall control from the bench
	input  wire logic stall_on,
	// Handshake to the mapper
	output logic      out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 32'h5765;
	initial out_ready = 1'b1;
	// Ready moves on the falling edge, so the mapper sees a settled level
	always @(negedge core_clk) begin
		out_ready <= stall_on ? ($random(seed) % 3 == 0) : 1'b1;
	end
endmodule
`default_nettype wire

// ===== bench/qam_constellation_mapper_tb.sv
// Self-checking bench for the constellation mapper
`default_nettype none
module qam_constellation_mapper_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int x; int y; logic e; logic [3:0] nb;} exp_t;
	localparam int X3[8] = '{1, 1, -1, -1, -3, 1, -1, 3};
	localparam int Y3[8] = '{1, -1, 1, -1, 1, 3, -3, -1};
	logic                core_clk = 1'b0;
	logic                srst     = 1'b1;
	logic                in_valid = 1'b0;
	logic [14:0]         in_bits  = 15'h0000;
	logic [3:0]          in_nbits = 4'h0;
	logic                in_dir   = 1'b0;
	logic [3:0]          bmax_dn  = 4'hF;
	logic [3:0]          bmax_up  = 4'hF;
	logic                stall_on = 1'b0;
	logic                exp_cfg  = 1'b0;
	logic                in_ready, out_valid, out_ready, out_err, cfg_err;
	logic [3:0]          out_nbits;
	qam_map_pkg::coord_t out_x, out_y, out_pt_x, out_pt_y;
	int                  err_count = 0;
	int                  cmp_count = 0;
	int                  seed = 32'h5765;
	exp_t                q[$];

	initial forever #12.5 core_clk = ~core_clk;

	qam_constellation_mapper uut (.core_clk(core_clk), .srst(srst),
		.in_valid(in_valid), .in_ready(in_ready), .in_bits(in_bits),
		.in_nbits(in_nbits), .in_dir(in_dir), .bmax_dn(bmax_dn),
		.bmax_up(bmax_up), .out_valid(out_valid), .out_ready(out_ready),
		.out_x(out_x), .out_y(out_y), .out_pt_x(out_pt_x),
		.out_pt_y(out_pt_y), .out_nbits(out_nbits), .out_err(out_err),
		.cfg_err(cfg_err));
	gain_sink sink (.core_clk(core_clk), .stall_on(stall_on),
		.out_ready(out_ready));

	// Shifts label bits hi, hi-2 .. down behind a top field, then a 1
	function automatic int build(input logic [14:0] v, input int top,
			input int hi);
		int u;
		u = top;
		for (int i = hi; i >= 0; i -= 2)
			u = (u << 1) | v[i];
		return (u << 1) | 1;
	endfunction
	// Two's complement reading of a w-bit field
	function automatic int sx(input int u, input int w);
		return (u >= (1 << (w - 1))) ? u - (1 << w) : u;
	endfunction
	// Reference point of one tone under the given ceiling
	function automatic exp_t ref_pt(input logic [14:0] v, input int b,
			input int cap);
		exp_t r;
		int t, xt, yt;
		r = '{0, 0, (b == 0) || (b > cap) || (cap < 8), b[3:0]};
		t = (b >= 5) ? (v >> (b - 5)) & 31 : 0;
		xt = (t[3] == t[2]) ? (t[1] ? 2 : 1) : (t[3] ? 3 : 0);
		yt = (t[3] == t[2]) ? (t[3] ? 3 : 0) : (t[0] ? 2 : 1);
		if (t < 16)
			xt = t[3] ? 3 : 0;
		if (t < 16)
			yt = t[2] ? 3 : 0;
		if (r.e)
			return r;
		if (b == 1)
			r = '{v[0] ? -1 : 1, v[0] ? -1 : 1, 1'b0, 4'h1};
		else if (b == 3)
			r = '{X3[v[2:0]], Y3[v[2:0]], 1'b0, 4'h3};
		else if (b % 2 == 0) begin
			r.x = sx(build(v, 0, b - 1), b / 2 + 1);
			r.y = sx(build(v, 0, b - 2), b / 2 + 1);
		end else begin
			r.x = sx(build(v, xt, b - 4), (b + 3) / 2);
			r.y = sx(build(v, yt, b - 5), (b + 3) / 2);
		end
		return r;
	endfunction
	// Gain giving unit mean energy, from the mean energy of each size
	function automatic int gain(input int b);
		real e;
		e = 2.0 * (31.0 * (2.0 ** (b - 5)) - 1.0) / 3.0;
		if (b % 2 == 0)
			e = 2.0 * ((2.0 ** b) - 1.0) / 3.0;
		else if (b < 5)
			e = (b == 1) ? 2.0 : 6.0;
		return $rtoi(32768.0 / $sqrt(e) + 0.5);
	endfunction

	task automatic final_report();
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Scaled outputs are allowed one step of rounding either way
	task automatic chk_near(input qam_map_pkg::coord_t got, input int exp);
		cmp_count++;
		if ($isunknown(got) || int'(got) - exp > 1 || exp - int'(got) > 1)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got,
				16'(exp));
		end
	endtask
	// Offers one tone and holds it until taken; called at a falling edge
	task automatic send(input logic [14:0] v, input int b, input logic d);
		int n;
		in_valid = 1'b1;
		in_bits = v;
		in_nbits = b[3:0];
		in_dir = d;
		// Ready is looked at once the sink has moved it on the falling edge
		for (n = 0; n < 60; n++) begin
			#1;
			if (in_ready === 1'b1)
				break;
			@(negedge core_clk);
		end
		if (n == 60) begin
			err_count++;
			final_report();
		end
		@(posedge core_clk);
		q.push_back(ref_pt(v, b, d ? bmax_up : bmax_dn));
		@(negedge core_clk);
	endtask

	// Points leave in order; each one taken is checked against the queue
	always @(posedge core_clk) begin
		exp_t e;
		exp_cfg <= !srst && ((in_dir ? bmax_up : bmax_dn) < 4'h8);
		if (!srst && out_valid === 1'b1 && out_ready === 1'b1) begin
			chk_v(16'(q.size() != 0), 16'h0001);
			if (q.size() != 0) begin
				e = q.pop_front();
				chk_v(16'(out_err), 16'(e.e));
				chk_v(16'(out_nbits), 16'(e.nb));
				chk_v(out_pt_x, 16'(e.x));
				chk_v(out_pt_y, 16'(e.y));
				chk_near(out_x, e.e ? 0 : e.x * gain(e.nb) / 4);
				chk_near(out_y, e.e ? 0 : e.y * gain(e.nb) / 4);
			end
		end
	end
	always @(negedge core_clk) begin
		if (!srst)
			chk_v(16'(cfg_err), 16'(exp_cfg));
	end

	initial begin
		int n;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		srst = 1'b0;
		chk_v({in_ready, out_valid, out_err}, 16'h0004);
		// Every small label, then edge labels of every size
		for (int b = 1; b <= 3; b++)
			for (int i = 0; i < (1 << b); i++)
				send(15'(i), b, 1'b0);
		for (int b = 0; b <= 15; b++) begin
			send(15'h0000, b, 1'b1);
			send(15'h7FFF, b, 1'b0);
			if (b >= 5)
				send(15'(18 << (b - 5)), b, 1'b1);
			if (b >= 5)
				send(15'(21 << (b - 5)), b, 1'b0);
		end
		// Tones above the ceiling and a ceiling out of range
		bmax_dn = 4'h8;
		send(15'h01FF, 9, 1'b0);
		send(15'h00FF, 8, 1'b0);
		bmax_up = 4'h7;
		send(15'h000F, 4, 1'b1);
		send(15'h000F, 4, 1'b0);
		bmax_up = 4'hF;
		// Random tones against a stalling sink
		stall_on = 1'b1;
		for (int i = 0; i < 600; i++) begin
			if (i % 50 == 0)
				bmax_dn = 4'h8 + 4'($unsigned($random(seed)) % 8);
			send(15'($random(seed)), 1 + $unsigned($random(seed)) % 15,
				1'($random(seed)));
		end
		in_valid = 1'b0;
		stall_on = 1'b0;
		for (n = 0; n < 100 && q.size() != 0; n++)
			@(negedge core_clk);
		chk_v(16'(q.size()), 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
